// [design/lb_pkg.sv]
/*
 Constants for the T1 line transmit, loop-back and loop code control.
 Assumes one 100 MHz clock and an Avalon-MM register slave.
*/
package lb_pkg;

  // ************
  // Register map
  // ************
  localparam logic [4:0] LINE_TX_LOOPBACK_OFS = 5'h00;
  localparam logic [4:0] LOOP_LINE_CODE_OFS = 5'h04;
  localparam logic [4:0] STATUS_OFS = 5'h08;
  localparam logic [4:0] IRQ_STATUS_OFS = 5'h0c;
  localparam logic [4:0] IRQ_CLEAR_OFS = 5'h10;
  localparam logic [4:0] IRQ_ENABLE_OFS = 5'h14;

  // ************
  // Fields and resets
  // ************
  localparam int TX_DRIVER_ON_BIT = 3;
  localparam int LOOPBACK_SEL_LSB = 0;
  localparam int DETECT_EN_LSB = 6;
  localparam int LINE_CODE_BIT = 5;
  localparam logic [7:0] LINE_TX_LOOPBACK_MASK = 8'h0f;
  localparam logic [7:0] LOOP_LINE_CODE_MASK = 8'hf8;
  localparam logic [7:0] LINE_TX_LOOPBACK_RESET = 8'h00;
  localparam logic [7:0] LOOP_LINE_CODE_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam int STS_REMOTE_BIT = 0;
  localparam int STS_DETECTED_BIT = 3;

  // ************
  // Encodings
  // ************
  localparam logic [2:0] LB_DUAL = 3'h4;
  localparam logic [2:0] LB_ANALOG = 3'h5;
  localparam logic [2:0] LB_REMOTE = 3'h6;
  localparam logic [2:0] LB_DIGITAL = 3'h7;
  localparam logic [1:0] DET_OFF = 2'h0;
  localparam logic [1:0] DET_UP = 2'h1;
  localparam logic [1:0] DET_DOWN = 2'h2;
  localparam logic [1:0] DET_AUTO = 2'h3;
  localparam int LOOP_UP_PERIOD = 5;
  localparam int LOOP_DOWN_PERIOD = 3;

  // ************
  // Timing
  // ************
  localparam int CLOCK_HZ = 100_000_000;
  localparam int LOOP_CODE_HOLD_S = 5;
  localparam logic [31:0] LOOP_CODE_HOLD_CYCLES =
    32'(LOOP_CODE_HOLD_S * CLOCK_HZ);

  typedef enum logic [1:0] {PH_IDLE, PH_AUTO_UP, PH_AUTO_DOWN} auto_phase_t;

endpackage : lb_pkg

// [design/loop_pattern_detect.sv]
/*
 Detector for a repeating code of PERIOD-1 zeros then one one.
 Assumes a one-cycle bit strobe, slower than the clock.
*/
`timescale 1ns/1ps
module loop_pattern_detect #(
  parameter int PERIOD = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Receive bits
  input wire logic bit_valid,
  input wire logic bit_in,
  // In lock
  output logic locked
);

  localparam logic [2:0] LAST_ZERO = 3'(PERIOD - 1);

  logic [2:0] zero_cnt_reg;
  logic seen_one_reg;

  // A one, then one whole period of PERIOD-1 zeros and a one, is needed before lock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      zero_cnt_reg <= 3'h0;
      seen_one_reg <= 1'b0;
      locked <= 1'b0;
    end else if (bit_valid) begin
      if (bit_in) begin
        locked <= seen_one_reg && (zero_cnt_reg == LAST_ZERO);
        seen_one_reg <= 1'b1;
        zero_cnt_reg <= 3'h0;
      end else if (zero_cnt_reg == LAST_ZERO) begin
        locked <= 1'b0;
        seen_one_reg <= 1'b0;
      end else begin
        zero_cnt_reg <= zero_cnt_reg + 3'h1;
      end
    end
  end

endmodule : loop_pattern_detect

// [design/persist_timer.sv]
/*
 Counts clock cycles while a level holds, saturating at a limit.
 Assumes the limit is steady.
*/
`timescale 1ns/1ps
module persist_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic clear,
  input wire logic active,
  input wire logic [31:0] limit,
  // Held long enough
  output logic done
);

  logic [31:0] count_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 32'h0;
    end else if (clear || !active) begin
      count_reg <= 32'h0;
    end else if (count_reg != limit) begin
      count_reg <= count_reg + 32'h1;
    end
  end

  // No clear term: the caller builds its clear from done
  assign done = active && (count_reg == limit);

endmodule : persist_timer

// [design/t1_line_loopback_loopcode_ctrl.sv]
/*
 Per-channel T1 line control: driver enable, loop-back select,
 loop code detection with automatic remote loop-back, line code.
 Assumes rx_bit is qualified by rx_bit_valid, both synchronous.
*/
`timescale 1ns/1ps
module t1_line_loopback_loopcode_ctrl
  import lb_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = LOOP_CODE_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Transmit line
  input wire logic transmit_driver_pin,
  input wire logic tx_tip_data,
  input wire logic tx_ring_data,
  output logic line_tx_tip,
  output logic line_tx_tip_oe,
  output logic line_tx_ring,
  output logic line_tx_ring_oe,
  // Receive line
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  // Modes to the datapath
  output logic loop_dual,
  output logic loop_analog,
  output logic loop_remote,
  output logic loop_digital,
  output logic line_code_select,
  output logic net_loop_code_detected,
  // Interrupt
  output logic irq
);

  // ************
  // Registers
  // ************
  logic [7:0] line_tx_and_loopback_control_reg;
  logic [7:0] loop_code_and_line_code_control_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic [7:0] irq_enable_reg;
  logic [1:0] mode_q_reg;
  logic auto_remote_reg;
  auto_phase_t phase_reg;

  logic [1:0] mode;
  logic [2:0] lb_sel;
  logic transmit_driver_on;
  logic wr_lane;
  logic up_locked;
  logic down_locked;
  logic watch_down;
  logic hold_clear;
  logic hold_done;
  logic [7:0] irq_events;
  logic [7:0] irq_clear;
  logic [7:0] rd_mux;

  assign mode = loop_code_and_line_code_control_reg[DETECT_EN_LSB +: 2];
  assign lb_sel = line_tx_and_loopback_control_reg[LOOPBACK_SEL_LSB +: 3];
  assign transmit_driver_on =
    line_tx_and_loopback_control_reg[TX_DRIVER_ON_BIT];
  assign wr_lane = write && !waitrequest && byteenable[0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ************
  // Bus slave
  // ************
  // One wait state: data are registered, waitrequest idles high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (address == LINE_TX_LOOPBACK_OFS) begin
      rd_mux = line_tx_and_loopback_control_reg;
    end else if (address == LOOP_LINE_CODE_OFS) begin
      rd_mux = loop_code_and_line_code_control_reg;
    end else if (address == STATUS_OFS) begin
      rd_mux[STS_DETECTED_BIT] = net_loop_code_detected;
      rd_mux[STS_REMOTE_BIT] = auto_remote_reg;
    end else if (address == IRQ_STATUS_OFS) begin
      rd_mux = irq_status_reg;
    end else if (address == IRQ_ENABLE_OFS) begin
      rd_mux = irq_enable_reg;
    end
  end

  // Unmapped and write-only addresses read as zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0;
    end else if (read && waitrequest) begin
      readdata <= {24'h0, rd_mux};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      line_tx_and_loopback_control_reg <= LINE_TX_LOOPBACK_RESET;
      loop_code_and_line_code_control_reg <= LOOP_LINE_CODE_RESET;
      irq_enable_reg <= IRQ_ENABLE_RESET;
    end else if (wr_lane) begin
      if (address == LINE_TX_LOOPBACK_OFS) begin
        line_tx_and_loopback_control_reg <=
          writedata[7:0] & LINE_TX_LOOPBACK_MASK;
      end else if (address == LOOP_LINE_CODE_OFS) begin
        loop_code_and_line_code_control_reg <=
          writedata[7:0] & LOOP_LINE_CODE_MASK;
      end else if (address == IRQ_ENABLE_OFS) begin
        irq_enable_reg <= writedata[7:0];
      end
    end
  end

  // ************
  // Transmit driver
  // ************
  // The outside pin gates the software bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      line_tx_tip <= 1'b0;
      line_tx_ring <= 1'b0;
      line_tx_tip_oe <= 1'b0;
      line_tx_ring_oe <= 1'b0;
    end else begin
      line_tx_tip <= tx_tip_data;
      line_tx_ring <= tx_ring_data;
      line_tx_tip_oe <= transmit_driver_on && transmit_driver_pin;
      line_tx_ring_oe <= transmit_driver_on && transmit_driver_pin;
    end
  end

  a_driver_off_tristate: assert property (
    !transmit_driver_on |=> !line_tx_tip_oe && !line_tx_ring_oe)
    else $error("driver not tri-stated while off");

  // ************
  // Loop-back and line code
  // ************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loop_dual <= 1'b0;
      loop_analog <= 1'b0;
      loop_remote <= 1'b0;
      loop_digital <= 1'b0;
      line_code_select <= 1'b0;
    end else begin
      loop_dual <= lb_sel == LB_DUAL;
      loop_analog <= lb_sel == LB_ANALOG;
      loop_remote <= (lb_sel == LB_REMOTE) || auto_remote_reg;
      loop_digital <= lb_sel == LB_DIGITAL;
      line_code_select <=
        loop_code_and_line_code_control_reg[LINE_CODE_BIT];
    end
  end

  a_loopback_off_decode: assert property (
    !lb_sel[2] && !auto_remote_reg |=>
      !loop_dual && !loop_analog && !loop_remote && !loop_digital)
    else $error("loop-back active with select off");
  a_line_code_ami: assert property (
    loop_code_and_line_code_control_reg[LINE_CODE_BIT] |=> line_code_select)
    else $error("AMI select not followed");

  // ************
  // Loop code detection
  // ************
  loop_pattern_detect #(.PERIOD(LOOP_UP_PERIOD)) up_detect (
    .clock(clock),
    .rst_b(rst_b),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .locked(up_locked)
  );

  loop_pattern_detect #(.PERIOD(LOOP_DOWN_PERIOD)) down_detect (
    .clock(clock),
    .rst_b(rst_b),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .locked(down_locked)
  );

  // Restart the hold count on any mode or phase change
  assign watch_down = (mode == DET_DOWN) || (phase_reg == PH_AUTO_DOWN);
  assign hold_clear = (mode != mode_q_reg) ||
    ((phase_reg != PH_IDLE) && hold_done);

  persist_timer hold_timer (
    .clock(clock),
    .rst_b(rst_b),
    .clear(hold_clear),
    .active((mode != DET_OFF) && (watch_down ? down_locked : up_locked)),
    .limit(HOLD_CYCLES),
    .done(hold_done)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= PH_IDLE;
    end else if (mode != DET_AUTO) begin
      phase_reg <= PH_IDLE;
    end else begin
      case (phase_reg)
        PH_IDLE: phase_reg <= PH_AUTO_UP;
        PH_AUTO_UP: if (hold_done) phase_reg <= PH_AUTO_DOWN;
        PH_AUTO_DOWN: if (hold_done) phase_reg <= PH_AUTO_UP;
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      auto_remote_reg <= 1'b0;
    end else if (mode != DET_AUTO) begin
      auto_remote_reg <= 1'b0;
    end else if (phase_reg == PH_AUTO_UP && hold_done) begin
      auto_remote_reg <= 1'b1;
    end else if (phase_reg == PH_AUTO_DOWN && hold_done) begin
      auto_remote_reg <= 1'b0;
    end
  end

  // Manual modes follow the code; automatic mode latches it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      net_loop_code_detected <= 1'b0;
    end else begin
      case (mode)
        DET_UP, DET_DOWN: net_loop_code_detected <=
          hold_done && (mode == mode_q_reg);
        DET_AUTO: begin
          if (mode_q_reg != DET_AUTO) begin
            net_loop_code_detected <= 1'b0;
          end else if (phase_reg == PH_AUTO_UP && hold_done) begin
            net_loop_code_detected <= 1'b1;
          end
        end
        default: net_loop_code_detected <= 1'b0;
      endcase
    end
  end

  a_detect_off_quiet: assert property (
    mode == DET_OFF |=> !net_loop_code_detected && !auto_remote_reg)
    else $error("detection active while disabled");
  a_up_flag_sets: assert property (
    mode == DET_UP && mode_q_reg == DET_UP && up_locked && hold_done
      |=> net_loop_code_detected)
    else $error("loop-up hold did not set the flag");
  a_down_flag_sets: assert property (
    mode == DET_DOWN && mode_q_reg == DET_DOWN && hold_done
      |=> net_loop_code_detected)
    else $error("loop-down hold did not set the flag");
  a_auto_entry_clear: assert property (
    mode == DET_AUTO && mode_q_reg != DET_AUTO
      |=> !net_loop_code_detected ##1 phase_reg == PH_AUTO_UP)
    else $error("automatic entry did not clear and arm");
  a_auto_remote_on: assert property (
    mode == DET_AUTO && phase_reg == PH_AUTO_UP && hold_done
      |=> auto_remote_reg && phase_reg == PH_AUTO_DOWN ##1 loop_remote)
    else $error("automatic mode did not turn to loop-down");
  a_auto_flag_holds: assert property (
    mode == DET_AUTO && mode_q_reg == DET_AUTO && net_loop_code_detected
      |=> net_loop_code_detected)
    else $error("automatic flag dropped");
  a_auto_remote_off: assert property (
    mode == DET_AUTO && phase_reg == PH_AUTO_DOWN && hold_done
      |=> !auto_remote_reg)
    else $error("loop-down did not release remote loop-back");

  // ************
  // Interrupts
  // ************
  logic detected_q_reg;
  logic remote_q_reg;
  // One-cycle-late copies for change and mode-switch detection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_q_reg <= DET_OFF;
      detected_q_reg <= 1'b0;
      remote_q_reg <= 1'b0;
    end else begin
      mode_q_reg <= mode;
      detected_q_reg <= net_loop_code_detected;
      remote_q_reg <= auto_remote_reg;
    end
  end

  always_comb begin
    irq_events = 8'h00;
    irq_events[STS_DETECTED_BIT] =
      net_loop_code_detected != detected_q_reg;
    irq_events[STS_REMOTE_BIT] = auto_remote_reg != remote_q_reg;
    irq_clear = 8'h00;
    if (wr_lane && address == IRQ_CLEAR_OFS) begin
      irq_clear = writedata[7:0];
    end
    // A new event beats a clear in the same cycle
    irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_reg <= 8'h00;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq <= |(irq_status_next & irq_enable_reg);
    end
  end

  a_change_raises_irq: assert property (
    net_loop_code_detected != detected_q_reg &&
      irq_enable_reg[STS_DETECTED_BIT] |=> irq)
    else $error("detection change raised no interrupt");

endmodule : t1_line_loopback_loopcode_ctrl

// [tb/t1_line_partner.sv]
/*
 Far-side model of the T1 line: sends loop code patterns on the receive
 strobe and shows what the tri-stated transmit pair carries.
 Assumes it shares the block's clock and reset.
*/
`timescale 1ns/1ps
module t1_line_partner (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Pattern: 0 all ones, 1 loop-up, 2 loop-down
  input wire logic [1:0] pattern,
  // Receive bits to the block
  output logic rx_bit_valid,
  output logic rx_bit,
  // Transmit pair from the block
  input wire logic line_tx_tip,
  input wire logic line_tx_tip_oe,
  input wire logic line_tx_ring,
  input wire logic line_tx_ring_oe,
  output logic tip_level,
  output logic ring_level
);
  logic [1:0] div_reg;
  int phase;
  int top;
  logic last_tip;
  logic last_ring;

  // ************
  // Receive bit source
  // ************
  assign top = (pattern == 2'h1) ? 4 : 2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 2'h0;
      phase <= 0;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      rx_bit_valid <= (div_reg == 2'h3);
      if (div_reg != 2'h3) begin
        rx_bit <= ~rx_bit; // Junk between strobes, never a held value
      end else if (pattern == 2'h0) begin
        rx_bit <= 1'b1;
      end else begin
        rx_bit <= (phase == top);
        phase <= (phase >= top) ? 0 : phase + 1;
      end
    end
  end

  // ************
  // Line pair: released wire shows the inverse of its last level
  // ************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      last_tip <= 1'b0;
      last_ring <= 1'b0;
    end else begin
      if (line_tx_tip_oe) last_tip <= line_tx_tip;
      if (line_tx_ring_oe) last_ring <= line_tx_ring;
    end
  end
  assign tip_level = line_tx_tip_oe ? line_tx_tip : ~last_tip;
  assign ring_level = line_tx_ring_oe ? line_tx_ring : ~last_ring;
endmodule : t1_line_partner

// [tb/tb_t1_line_loopback_loopcode_ctrl.sv]
/*
 Self-checking bench for the T1 line control block, with a register
 model in integers. Assumes the line partner model beside it.
*/
`timescale 1ns/1ps
module tb_t1_line_loopback_loopcode_ctrl;
  import lb_pkg::*;
  // Short hold stands in for 5 s
  localparam logic [31:0] HOLD = 32'h32;
  logic clock = 1'b0;
  logic rst_b, read, write, waitrequest, irq, pin, tip_d, ring_d;
  logic [4:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic tip, tip_oe, ring, ring_oe, rx_v, rx_b, tip_level, ring_level;
  logic loop_dual, loop_analog, loop_remote, loop_digital, code_sel, flag;
  logic [1:0] pattern;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 32'h2886;
  int m_ctl, m_code, m_ien, m_ists, m_sts, i;

  always #5 clock = ~clock;

  t1_line_loopback_loopcode_ctrl #(.HOLD_CYCLES(HOLD)) dut (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .transmit_driver_pin(pin), .tx_tip_data(tip_d), .tx_ring_data(ring_d),
    .line_tx_tip(tip), .line_tx_tip_oe(tip_oe), .line_tx_ring(ring),
    .line_tx_ring_oe(ring_oe), .rx_bit_valid(rx_v), .rx_bit(rx_b),
    .loop_dual(loop_dual), .loop_analog(loop_analog),
    .loop_remote(loop_remote), .loop_digital(loop_digital),
    .line_code_select(code_sel), .net_loop_code_detected(flag), .irq(irq));

  t1_line_partner partner (
    .clock(clock), .rst_b(rst_b), .pattern(pattern), .rx_bit_valid(rx_v),
    .rx_bit(rx_b), .line_tx_tip(tip), .line_tx_tip_oe(tip_oe),
    .line_tx_ring(ring), .line_tx_ring_oe(ring_oe),
    .tip_level(tip_level), .ring_level(ring_level));

  // ************
  // Report and compare
  // ************
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // ************
  // Avalon master and model
  // ************
  task bus(input logic is_wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    address <= a;
    read <= ~is_wr;
    write <= is_wr;
    writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
  endtask : bus

  function automatic logic [31:0] exp_rd(input logic [4:0] a);
    case (a)
      LINE_TX_LOOPBACK_OFS: return 32'(m_ctl);
      LOOP_LINE_CODE_OFS: return 32'(m_code);
      STATUS_OFS: return 32'(m_sts);
      IRQ_STATUS_OFS: return 32'(m_ists);
      IRQ_ENABLE_OFS: return 32'(m_ien);
      default: return 32'h0;
    endcase
  endfunction : exp_rd

  task rchk(input logic [4:0] a);
    bus(1'b0, a, 8'h00);
    chk_word(q, exp_rd(a));
  endtask : rchk

  task wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    case (a)
      LINE_TX_LOOPBACK_OFS: m_ctl = d & LINE_TX_LOOPBACK_MASK;
      LOOP_LINE_CODE_OFS: m_code = d & LOOP_LINE_CODE_MASK;
      IRQ_CLEAR_OFS: m_ists = m_ists & ~int'(d);
      IRQ_ENABLE_OFS: m_ien = d;
      default: ;
    endcase
  endtask : wr

  task wait_out(input logic remote, input logic v);
    int n;
    n = 0;
    while ((remote ? loop_remote : flag) !== v && n < 1000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 1000) begin
      miscompares++;
      final_report();
    end
  endtask : wait_out

  task settle;
    repeat (3) @(posedge clock);
  endtask : settle

  task manual(input logic [7:0] code, input logic [1:0] pat,
              input logic [7:0] en);
    wr(IRQ_ENABLE_OFS, en);
    wr(LOOP_LINE_CODE_OFS, code);
    pattern <= pat;
    wait_out(1'b0, 1'b1);
    settle;
    m_sts = 8;
    m_ists = 8;
    rchk(STATUS_OFS);
    rchk(IRQ_STATUS_OFS);
    chk_bit(irq, |(m_ists & m_ien));
    chk_bit(loop_remote, 1'b0);
    wr(IRQ_CLEAR_OFS, 8'h08);
    settle;
    chk_bit(irq, 1'b0);
    pattern <= 2'h0;
    wait_out(1'b0, 1'b0);
    settle;
    m_sts = 0;
    m_ists = 8;
    rchk(IRQ_STATUS_OFS);
    chk_bit(irq, |(m_ists & m_ien));
    wr(IRQ_CLEAR_OFS, 8'h08);
    $display("test manual %h finished", code);
  endtask : manual

  // ************
  // Main sequence
  // ************
  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'h1;
    pin = 1'b1;
    tip_d = 1'b0;
    ring_d = 1'b0;
    pattern = 2'h0;
    {m_ctl, m_code, m_ien, m_ists, m_sts} = '0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    chk_bit(tip_oe, 1'b0);
    for (i = 0; i < 32; i += 4) rchk(i[4:0]);
    chk_bit(irq, 1'b0);
    $display("test reset finished");
    for (i = 0; i < 16; i++) begin
      pin <= 1'($random(seed));
      tip_d <= 1'($random(seed));
      ring_d <= 1'($random(seed));
      wr(LINE_TX_LOOPBACK_OFS, {4'($random(seed)), i[3:0]});
      rchk(LINE_TX_LOOPBACK_OFS);
      settle;
      chk_bit(loop_dual, i[2:0] == LB_DUAL);
      chk_bit(loop_analog, i[2:0] == LB_ANALOG);
      chk_bit(loop_remote, i[2:0] == LB_REMOTE);
      chk_bit(loop_digital, i[2:0] == LB_DIGITAL);
      chk_bit(tip_oe, i[3] & pin);
      chk_bit(ring_oe, i[3] & pin);
      if (i[3] & pin) chk_bit(tip_level, tip_d);
      if (i[3] & pin) chk_bit(ring_level, ring_d);
    end
    wr(5'h1c, 8'hff);
    byteenable <= 4'h0;
    bus(1'b1, LINE_TX_LOOPBACK_OFS, 8'h0a);
    byteenable <= 4'h1;
    rchk(LINE_TX_LOOPBACK_OFS);
    for (i = 0; i < 2; i++) begin
      wr(LOOP_LINE_CODE_OFS, {2'b00, i[0], 5'($random(seed))});
      rchk(LOOP_LINE_CODE_OFS);
      settle;
      chk_bit(code_sel, i[0]);
    end
    $display("test control finished");
    for (i = 0; i < 3; i++) begin
      wr(LOOP_LINE_CODE_OFS, (i == 0) ? 8'h00 : ((i == 1) ? 8'h80 : 8'h40));
      pattern <= (i == 2) ? 2'h2 : 2'h1;
      repeat (200) @(posedge clock);
      chk_bit(flag, 1'b0);
    end
    pattern <= 2'h0;
    manual(8'h40, 2'h1, 8'h08);
    manual(8'h80, 2'h2, 8'h00);
    wr(LOOP_LINE_CODE_OFS, 8'h40);
    pattern <= 2'h1;
    wait_out(1'b0, 1'b1);
    wr(LOOP_LINE_CODE_OFS, 8'hc0);
    repeat (3) @(posedge clock);
    chk_bit(flag, 1'b0);
    wait_out(1'b0, 1'b1);
    settle;
    chk_bit(loop_remote, 1'b1);
    m_sts = 9;
    m_ists = 9;
    rchk(STATUS_OFS);
    rchk(IRQ_STATUS_OFS);
    pattern <= 2'h0;
    repeat (300) @(posedge clock);
    chk_bit(flag, 1'b1);
    pattern <= 2'h1;
    repeat (300) @(posedge clock);
    chk_bit(loop_remote, 1'b1);
    wr(IRQ_CLEAR_OFS, 8'h09);
    wr(IRQ_ENABLE_OFS, 8'h01);
    pattern <= 2'h2;
    wait_out(1'b1, 1'b0);
    settle;
    bus(1'b0, STATUS_OFS, 8'h00);
    chk_word(q & 32'h1, 32'h0);
    chk_bit(irq, 1'b1);
    $display("test automatic finished");
    final_report();
  end
endmodule : tb_t1_line_loopback_loopcode_ctrl
